// ===== rtl/wfd_pkg.sv
/*
 Shared constants and types of the wake frame detector: register offsets,
 control field positions, filter word layout, CRC settings and the state record.
 Assumes a single 10 MHz clock domain and a receive byte stream on that clock.
*/
package wfd_pkg;
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;    // wake_control_status_reg
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h04;  // Sticky events, read only
   localparam logic [ADDR_W-1:0] OFS_CLEAR = 5'h08;   // Write one to clear
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 5'h0c;  // Event enable
   localparam logic [ADDR_W-1:0] OFS_LOAD = 5'h10;    // wake_filter_load_port
   localparam logic [ADDR_W-1:0] OFS_STA_LO = 5'h14;  // Station address bytes 0..3
   localparam logic [ADDR_W-1:0] OFS_STA_HI = 5'h18;  // Station address bytes 4..5
   // Control register fields
   localparam int CTL_FRAME_EN = 0;     // frame_wake_enable
   localparam int CTL_PAT_EN = 1;       // addr_pattern_wake_enable
   localparam int CTL_NOTIFY_PWR = 2;   // 1: power_event_output, 0: host interrupt
   localparam int CTL_SLEEP = 3;        // light_sleep_state entered
   localparam int CTL_FRAME_SEEN = 4;   // frame_wake_seen mirror
   localparam int CTL_PAT_SEEN = 5;     // addr_pattern_wake_seen mirror
   // Event bits of status, clear and enable registers
   localparam int EV_FRAME = 0;
   localparam int EV_PAT = 1;
   // Filter word layout behind the load port
   localparam int NUM_FILT = 4;
   localparam int LOAD_WORDS = 8;
   localparam int W_MASK0 = 0;
   localparam int W_CMD = 4;
   localparam int W_OFS = 5;
   localparam int W_CRC01 = 6;
   localparam int W_CRC23 = 7;
   localparam int MASK_LEN = 31;
   localparam int CMD_EN = 0;
   localparam int CMD_MCAST = 3;
   localparam int PAT_START = 12;       // First byte after both address fields
   localparam int SYNC_LEN = 6;
   localparam int ADDR_COPIES = 16;
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [8:0] POS_MAX = 9'h1ff;

   typedef enum logic [2:0] {
      WFD_SEEK = 3'b001,
      WFD_ADDR = 3'b010,
      WFD_DONE = 3'b100
   } wfd_scan_t;

   typedef struct packed {
      logic valid;
      logic sof;
      logic eof;
      logic [7:0] data;
   } wfd_rx_t;

   typedef struct packed {
      logic fwen;
      logic apen;
      logic sel_pwr;
      logic sleep;
      logic [1:0] sts;
      logic [1:0] ien;
      logic [2:0] ptr;
      logic [LOAD_WORDS-1:0][31:0] filt;
      logic [47:0] sta;
      logic [31:0] rdata;
      logic irq;
      logic pwr_ev;
      logic rxn;
      logic [8:0] pos;
      logic [NUM_FILT-1:0][15:0] crc;
      logic mcast;
      logic da_own;
      logic da_bc;
      wfd_scan_t scan;
      logic [2:0] ffc;
      logic [2:0] bidx;
      logic [4:0] copies;
   } wfd_state_t;
endpackage

// ===== rtl/wfd_wake_detect.sv
/*
 Wake frame detector: four masked CRC-16 pattern filters and a detector for a
 sync stream followed by sixteen copies of the station address, with a small
 register port, sticky events and host interrupt or power event notification.
 Assumes the receive bytes come from MAC logic on sys_clk (no synchroniser),
 one byte per valid cycle, sof and eof marking the first and last byte.
*/
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ns
`default_nettype none

module wfd_wake_detect (
   input wire logic sys_clk_i,                          // 10 MHz clock
   input wire logic sys_rst_i,                          // Synchronous reset, active high
   input wire logic [wfd_pkg::ADDR_W-1:0] reg_addr_i,   // Register byte address
   input wire logic [31:0] reg_wdata_i,                 // Write data
   input wire logic reg_wr_i,                           // Write strobe
   input wire logic reg_rd_i,                           // Read strobe
   output logic [31:0] reg_rdata_o,                     // Read data, cycle after strobe
   input wire wfd_pkg::wfd_rx_t rx_i,                   // Received frame bytes
   output logic rx_normal_o,                            // Ordinary reception allowed
   output logic irq_o,                                  // Host interrupt, level
   output logic power_event_output_o                    // Power event, level
);

   localparam int NUM_FILT_C = wfd_pkg::NUM_FILT;

   wfd_pkg::wfd_state_t s_reg;
   wfd_pkg::wfd_state_t s_next;

   // Bit-serial update, MSB first
   function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int b = 7; b >= 0; b--) begin
         if (r[15] ^ d[b]) begin
            r = {r[14:0], 1'b0} ^ wfd_pkg::CRC_POLY;
         end else begin
            r = {r[14:0], 1'b0};
         end
      end
      return r;
   endfunction

   // Byte n of the station address, byte 0 first on the wire
   function automatic logic [7:0] sta_byte(input logic [47:0] a, input logic [2:0] n);
      logic [7:0] r;
      r = 8'h00;
      for (int k = 0; k < 6; k++) begin
         if (n == 3'(k)) begin
            r = a[8*k +: 8];
         end
      end
      return r;
   endfunction

   always_comb begin
      logic [8:0] p;
      logic [8:0] idx;
      logic [7:0] ofs;
      logic [3:0] cmd;
      logic [15:0] ref_crc;
      logic [NUM_FILT_C-1:0] hit;
      logic mc;
      logic own;
      logic bc;
      logic frame_on;
      logic pat_on;
      logic found;
      logic [1:0] ev;
      logic [1:0] clr;
      logic pend;
      p = '0;
      idx = '0;
      ofs = '0;
      cmd = '0;
      ref_crc = '0;
      hit = '0;
      mc = 1'b0;
      own = 1'b0;
      bc = 1'b0;
      found = 1'b0;
      ev = '0;
      clr = '0;
      frame_on = 1'b0;
      pat_on = 1'b0;
      pend = 1'b0;
      s_next = s_reg;
      s_next.rdata = 32'h0000_0000;
      // Light sleep forces both detectors on
      frame_on = s_reg.fwen | s_reg.sleep;
      pat_on = s_reg.apen | s_reg.sleep;

      // Receive path
      if (rx_i.valid) begin
         p = rx_i.sof ? 9'h000 : s_reg.pos;
         s_next.pos = (p == wfd_pkg::POS_MAX) ? p : p + 9'h001;
         mc = (p == 9'h000) ? rx_i.data[0] : s_reg.mcast;
         s_next.mcast = mc;
         own = (p == 9'h000) ? 1'b1 : s_reg.da_own;
         bc = (p == 9'h000) ? 1'b1 : s_reg.da_bc;
         if (p < 9'd6) begin
            own = own & (rx_i.data == sta_byte(s_reg.sta, p[2:0]));
            bc = bc & (rx_i.data == 8'hff);
         end
         s_next.da_own = own;
         s_next.da_bc = bc;

         for (int i = 0; i < NUM_FILT_C; i++) begin
            ofs = s_reg.filt[wfd_pkg::W_OFS][8*i +: 8];
            cmd = s_reg.filt[wfd_pkg::W_CMD][8*i +: 4];
            ref_crc = s_reg.filt[wfd_pkg::W_CRC01 + i/2][16*(i%2) +: 16];
            s_next.crc[i] = rx_i.sof ? wfd_pkg::CRC_INIT : s_reg.crc[i];
            idx = p - {1'b0, ofs};
            // Mask bit 31 is never consulted, only 31 byte positions exist
            if (p >= {1'b0, ofs} && idx < 9'(wfd_pkg::MASK_LEN) &&
                s_reg.filt[wfd_pkg::W_MASK0 + i][idx[4:0]]) begin
               s_next.crc[i] = crc16_byte(s_next.crc[i], rx_i.data);
            end
            hit[i] = cmd[wfd_pkg::CMD_EN] &&
                     (cmd[wfd_pkg::CMD_MCAST] == mc) &&
                     (s_next.crc[i] == ref_crc);
         end

         // Address-pattern scan restarts with every frame
         if (rx_i.sof) begin
            s_next.scan = wfd_pkg::WFD_SEEK;
            s_next.ffc = 3'h0;
            s_next.bidx = 3'h0;
            s_next.copies = 5'h00;
         end
         if (p >= 9'(wfd_pkg::PAT_START)) begin
            unique case (s_next.scan)
               wfd_pkg::WFD_SEEK: begin
                  if (rx_i.data == 8'hff) begin
                     if (s_next.ffc == 3'(wfd_pkg::SYNC_LEN - 1) ||
                         s_next.ffc == 3'(wfd_pkg::SYNC_LEN)) begin
                        s_next.ffc = 3'(wfd_pkg::SYNC_LEN);
                     end else begin
                        s_next.ffc = s_next.ffc + 3'h1;
                     end
                  end else if (s_next.ffc == 3'(wfd_pkg::SYNC_LEN) &&
                               rx_i.data == sta_byte(s_reg.sta, 3'h0)) begin
                     s_next.scan = wfd_pkg::WFD_ADDR;
                     s_next.bidx = 3'h1;
                     s_next.copies = 5'h00;
                  end else begin
                     s_next.ffc = 3'h0;
                  end
               end
               wfd_pkg::WFD_ADDR: begin
                  if (rx_i.data == sta_byte(s_reg.sta, s_next.bidx)) begin
                     if (s_next.bidx == 3'h5) begin
                        s_next.bidx = 3'h0;
                        if (s_next.copies == 5'(wfd_pkg::ADDR_COPIES - 1)) begin
                           s_next.scan = wfd_pkg::WFD_DONE;
                        end
                        s_next.copies = s_next.copies + 5'h01;
                     end else begin
                        s_next.bidx = s_next.bidx + 3'h1;
                     end
                  end else begin
                     // A break restarts the sync search; this byte may begin it
                     s_next.scan = wfd_pkg::WFD_SEEK;
                     s_next.ffc = (rx_i.data == 8'hff) ? 3'h1 : 3'h0;
                     s_next.copies = 5'h00;
                  end
               end
               wfd_pkg::WFD_DONE: begin
                  s_next.scan = wfd_pkg::WFD_DONE;
               end
            endcase
         end
         found = (s_next.scan == wfd_pkg::WFD_DONE);

         // Decisions at the last byte of the frame
         if (rx_i.eof) begin
            ev[wfd_pkg::EV_FRAME] = frame_on & (|hit);
            ev[wfd_pkg::EV_PAT] = pat_on & found & (own | bc | mc);
         end
      end

      // Register writes
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            wfd_pkg::OFS_CTRL: begin
               s_next.fwen = reg_wdata_i[wfd_pkg::CTL_FRAME_EN];
               s_next.apen = reg_wdata_i[wfd_pkg::CTL_PAT_EN];
               s_next.sel_pwr = reg_wdata_i[wfd_pkg::CTL_NOTIFY_PWR];
               s_next.sleep = reg_wdata_i[wfd_pkg::CTL_SLEEP];
            end
            wfd_pkg::OFS_CLEAR: clr = reg_wdata_i[1:0];
            wfd_pkg::OFS_IRQ_EN: s_next.ien = reg_wdata_i[1:0];
            wfd_pkg::OFS_LOAD: begin
               // Eight writes in a row fill the filters, then the pointer wraps
               s_next.filt[s_reg.ptr] = reg_wdata_i;
               s_next.ptr = s_reg.ptr + 3'h1;
            end
            wfd_pkg::OFS_STA_LO: s_next.sta[31:0] = reg_wdata_i;
            wfd_pkg::OFS_STA_HI: s_next.sta[47:32] = reg_wdata_i[15:0];
            default: s_next.ptr = s_reg.ptr;
         endcase
      end

      // An event in the clearing cycle survives
      s_next.sts = (s_reg.sts & ~clr) | ev;

      // Register reads, answered in the next cycle
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            wfd_pkg::OFS_CTRL: begin
               s_next.rdata[wfd_pkg::CTL_FRAME_EN] = s_reg.fwen;
               s_next.rdata[wfd_pkg::CTL_PAT_EN] = s_reg.apen;
               s_next.rdata[wfd_pkg::CTL_NOTIFY_PWR] = s_reg.sel_pwr;
               s_next.rdata[wfd_pkg::CTL_SLEEP] = s_reg.sleep;
               s_next.rdata[wfd_pkg::CTL_FRAME_SEEN] = s_reg.sts[wfd_pkg::EV_FRAME];
               s_next.rdata[wfd_pkg::CTL_PAT_SEEN] = s_reg.sts[wfd_pkg::EV_PAT];
            end
            wfd_pkg::OFS_STATUS: s_next.rdata[1:0] = s_reg.sts;
            wfd_pkg::OFS_IRQ_EN: s_next.rdata[1:0] = s_reg.ien;
            wfd_pkg::OFS_STA_LO: s_next.rdata = s_reg.sta[31:0];
            wfd_pkg::OFS_STA_HI: s_next.rdata[15:0] = s_reg.sta[47:32];
            default: s_next.rdata = 32'h0000_0000;
         endcase
      end

      // Notification uses the updated flags so the output follows the event by one edge
      pend = |(s_next.sts & s_next.ien);
      s_next.irq = pend & ~s_next.sel_pwr;
      s_next.pwr_ev = pend & s_next.sel_pwr;
      s_next.rxn = ~(s_next.fwen | s_next.apen | s_next.sleep);
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         s_reg <= '0;
         s_reg.rxn <= 1'b1;
         s_reg.scan <= wfd_pkg::WFD_SEEK;
         for (int i = 0; i < wfd_pkg::NUM_FILT; i++) begin
            s_reg.crc[i] <= wfd_pkg::CRC_INIT;
         end
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata_o = s_reg.rdata;
   assign rx_normal_o = s_reg.rxn;
   assign irq_o = s_reg.irq;
   assign power_event_output_o = s_reg.pwr_ev;

endmodule // wfd_wake_detect

`default_nettype wire

// ===== tb/wfd_wake_detect_properties.sv
/*
 Port-level checker of the wake frame detector, bound to the top module.
 Assumes the single sys_clk_i domain and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none

module wfd_wake_detect_properties (
   input wire logic sys_clk_i, // Clock
   input wire logic sys_rst_i, // Reset
   input wire logic [wfd_pkg::ADDR_W-1:0] reg_addr_i, // Address
   input wire logic [31:0] reg_wdata_i, // Write data
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   input wire logic [31:0] reg_rdata_o, // Read data
   input wire wfd_pkg::wfd_rx_t rx_i, // Frame bytes
   input wire logic rx_normal_o, // Ordinary reception
   input wire logic irq_o, // Host interrupt
   input wire logic power_event_output_o // Power event
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence ctrl_wr_s;
      reg_wr_i && reg_addr_i == wfd_pkg::OFS_CTRL;
   endsequence
   sequence wake_on_s;
      ctrl_wr_s ##0 (reg_wdata_i[0] || reg_wdata_i[1] || reg_wdata_i[3]);
   endsequence
   sequence wake_off_s;
      ctrl_wr_s ##0 !(reg_wdata_i[0] || reg_wdata_i[1] || reg_wdata_i[3]);
   endsequence
   // An eof in the same cycle may set a bit again, so it is left out
   sequence clear_all_s;
      reg_wr_i && reg_addr_i == wfd_pkg::OFS_CLEAR && reg_wdata_i[1:0] == 2'b11
         && !(rx_i.valid && rx_i.eof);
   endsequence
   rx_suspend_a: assert property (wake_on_s |=> !rx_normal_o)
      else $error("reception not suspended by enable");
   rx_resume_a: assert property (wake_off_s |=> rx_normal_o)
      else $error("reception not restored");
   rx_cause_a: assert property ($changed(rx_normal_o) |-> $past(sys_rst_i)
      || ($past(reg_wr_i) && $past(reg_addr_i) == wfd_pkg::OFS_CTRL))
      else $error("reception mode changed without control write");
   notify_excl_a: assert property (!(irq_o && power_event_output_o))
      else $error("both notifications high");
   notify_cause_a: assert property ($rose(irq_o) || $rose(power_event_output_o)
      |-> $past(rx_i.valid && rx_i.eof) || $past(reg_wr_i))
      else $error("notification rose without frame end or write");
   quiet_normal_a: assert property (rx_normal_o && !reg_wr_i
      |=> !$rose(irq_o) && !$rose(power_event_output_o))
      else $error("event while detection off");
   clear_all_a: assert property (clear_all_s |=> !irq_o && !power_event_output_o)
      else $error("notification stays after clear");
   sel_host_a: assert property (ctrl_wr_s ##0 !reg_wdata_i[2] |=> !power_event_output_o)
      else $error("power event with host select");
   load_read_a: assert property (reg_rd_i && (reg_addr_i == wfd_pkg::OFS_LOAD
      || reg_addr_i == wfd_pkg::OFS_CLEAR) |=> reg_rdata_o == 32'h0)
      else $error("write-only place read non-zero");
endmodule // wfd_wake_detect_properties

bind wfd_wake_detect wfd_wake_detect_properties i_props (.sys_clk_i, .sys_rst_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .rx_i, .rx_normal_o, .irq_o,
   .power_event_output_o);

`default_nettype wire

// ===== tb/wfd_frame_src.sv
/*
 Receive side model: hands whole frames to the detector, one byte per cycle.
 Assumes the caller enters send just after a rising edge of clk_i.
*/
`timescale 1ns/1ns
`default_nettype none

module wfd_frame_src (
   input wire logic clk_i, // Clock
   output var wfd_pkg::wfd_rx_t rx_o // Byte stream
);
   logic busy = 1'b0;
   initial rx_o = '0;
   // Idle data keeps changing so a stale byte never looks like frame content
   always @(posedge clk_i) if (!busy) rx_o <= '{1'b0, 1'b0, 1'b0, ~rx_o.data};
   task automatic send(input logic [7:0] fr[$]);
      busy = 1'b1;
      foreach (fr[k]) begin
         @(posedge clk_i);
         rx_o <= '{1'b1, k == 0, k == fr.size() - 1, fr[k]};
      end
      @(posedge clk_i);
      rx_o <= '{1'b0, 1'b0, 1'b0, ~fr[fr.size() - 1]};
      busy <= 1'b0;
   endtask
endmodule // wfd_frame_src

`default_nettype wire

// ===== tb/wfd_wake_detect_bench.sv
/*
 Self-checking bench of the wake frame detector: register port, filters,
 address pattern detection, sleep and notification.
 Assumes the frame model wfd_frame_src and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none

module wfd_wake_detect_bench;
   localparam logic [47:0] STA = 48'h554433221100; // Byte 0 is 0x00, a unicast address
   logic sys_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, rx_normal_o, irq_o, power_event_output_o;
   logic [wfd_pkg::ADDR_W-1:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o;
   wfd_pkg::wfd_rx_t rx_i;
   logic [7:0] fq[$];
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   wfd_wake_detect i_dut (.sys_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .rx_i, .rx_normal_o, .irq_o, .power_event_output_o);
   wfd_frame_src i_src (.clk_i(sys_clk_i), .rx_o(rx_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_total++;
         give_verdict();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [wfd_pkg::ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rdc(input string n, input logic [wfd_pkg::ADDR_W-1:0] a, input logic [31:0] e);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(n, reg_rdata_o, e);
   endtask
   task automatic hdr(input logic [47:0] da);
      fq = {};
      for (int i = 0; i < 12; i++) fq.push_back(i < 6 ? da[8*i +: 8] : 8'h02);
   endtask
   task automatic sync_copies(input int n);
      repeat (6) fq.push_back(8'hff);
      for (int i = 0; i < 6 * n; i++) fq.push_back(STA[8*(i%6) +: 8]);
   endtask
   // Reference CRC of the current frame for a filter starting at offset o
   function automatic logic [15:0] crc16(input int o, input logic [30:0] m);
      logic [15:0] c;
      c = wfd_pkg::CRC_INIT;
      for (int p = o; p < fq.size(); p++)
         if (p < o + 31 && m[p-o]) for (int b = 7; b >= 0; b--)
            c = {c[14:0], 1'b0} ^ (c[15] ^ fq[p][b] ? wfd_pkg::CRC_POLY : 16'h0000);
      return c;
   endfunction
   task automatic t_off();
      wr(wfd_pkg::OFS_CTRL, 32'h0);
      rdc("ctrl", wfd_pkg::OFS_CTRL, 32'h0);
      chk("rx_normal", rx_normal_o, 1'b1);
   endtask
   task automatic t_reset();
      // Look once the last reset edge has settled
      #1;
      chk("rx_normal", rx_normal_o, 1'b1);
      chk("notify", {irq_o, power_event_output_o}, 2'b00);
      rdc("status", wfd_pkg::OFS_STATUS, 32'h0);
      rdc("enable", wfd_pkg::OFS_IRQ_EN, 32'h0);
      rdc("unmapped", 5'h1c, 32'h0);
   endtask
   task automatic t_frame();
      logic [15:0] c;
      logic [15:0] c0;
      hdr(48'h0000000000e1);
      for (int i = 0; i < 8; i++) fq.push_back(8'h10 + i[7:0]);
      c = crc16(12, 31'h5);
      c0 = crc16(14, 31'h5);
      for (int i = 0; i < 3; i++) wr(wfd_pkg::OFS_LOAD, 32'h5);
      wr(wfd_pkg::OFS_LOAD, 32'h0);
      wr(wfd_pkg::OFS_LOAD, 32'h00090801); // f0 unicast, f1 off, f2 multicast
      wr(wfd_pkg::OFS_LOAD, 32'h0c0c0c0e); // f0 starts at 14
      wr(wfd_pkg::OFS_LOAD, {c, c0});
      wr(wfd_pkg::OFS_LOAD, {16'h0, ~c});
      rdc("load", wfd_pkg::OFS_LOAD, 32'h0);
      wr(wfd_pkg::OFS_IRQ_EN, 32'h1);
      wr(wfd_pkg::OFS_CTRL, 32'h1);
      // Multicast frame: only the unicast f0 and the disabled f1 hold their CRC
      i_src.send(fq);
      rdc("status", wfd_pkg::OFS_STATUS, 32'h0);
      chk("rx_normal", rx_normal_o, 1'b0);
      fq[0] = 8'h00;
      i_src.send(fq);
      rdc("status", wfd_pkg::OFS_STATUS, 32'h1);
      chk("notify", {irq_o, power_event_output_o}, 2'b10);
      rdc("ctrl", wfd_pkg::OFS_CTRL, 32'h11);
      wr(wfd_pkg::OFS_CLEAR, 32'h1);
      rdc("status", wfd_pkg::OFS_STATUS, 32'h0);
      chk("irq", irq_o, 1'b0);
      t_off();
   endtask
   task automatic t_pattern();
      wr(wfd_pkg::OFS_STA_LO, STA[31:0]);
      wr(wfd_pkg::OFS_STA_HI, {16'h0, STA[47:32]});
      rdc("sta lo", wfd_pkg::OFS_STA_LO, STA[31:0]);
      rdc("sta hi", wfd_pkg::OFS_STA_HI, {16'h0, STA[47:32]});
      wr(wfd_pkg::OFS_IRQ_EN, 32'h2);
      wr(wfd_pkg::OFS_CTRL, 32'h6);
      hdr(STA);
      sync_copies(15);
      fq.push_back(8'h5a);
      i_src.send(fq);
      rdc("status", wfd_pkg::OFS_STATUS, 32'h0);
      hdr(48'h0000000000e0);
      sync_copies(16);
      i_src.send(fq);
      rdc("status", wfd_pkg::OFS_STATUS, 32'h0);
      hdr(STA);
      sync_copies(3);
      fq.push_back(8'h5a);
      sync_copies(16);
      fq.push_back(8'h5a);
      i_src.send(fq);
      rdc("status", wfd_pkg::OFS_STATUS, 32'h2);
      chk("notify", {irq_o, power_event_output_o}, 2'b01);
      rdc("ctrl", wfd_pkg::OFS_CTRL, 32'h26);
      wr(wfd_pkg::OFS_CLEAR, 32'h2);
      rdc("status", wfd_pkg::OFS_STATUS, 32'h0);
      chk("power event", power_event_output_o, 1'b0);
      t_off();
   endtask
   task automatic t_sleep();
      wr(wfd_pkg::OFS_IRQ_EN, 32'h3);
      wr(wfd_pkg::OFS_CTRL, 32'h8);
      hdr(48'hffffffffffff);
      sync_copies(16);
      i_src.send(fq);
      rdc("status", wfd_pkg::OFS_STATUS, 32'h2);
      chk("rx_normal", rx_normal_o, 1'b0);
      chk("irq", irq_o, 1'b1);
      wr(wfd_pkg::OFS_IRQ_EN, 32'h0);
      rdc("enable", wfd_pkg::OFS_IRQ_EN, 32'h0);
      chk("irq masked", irq_o, 1'b0);
      wr(wfd_pkg::OFS_CLEAR, 32'h3);
      t_off();
   endtask
   initial begin
      sys_rst_i = 1'b1;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = '0;
      reg_wdata_i = '0;
      repeat (16) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_frame();
      t_pattern();
      t_sleep();
      give_verdict();
   end
endmodule // wfd_wake_detect_bench

`default_nettype wire
